// ===== rtl/csri_pkg.sv
// System register bank package: data map, field positions, reset values, carriers.
// Assumes one 20 MHz clock and an 8-bit data space reached as one word per address.
package csri_pkg;
   localparam int         AXI_AW     = 10;                 // 256 data addresses, one word each
   localparam int         SRAM_DEPTH = 128;
   localparam int         SRAM_AW    = 7;
   // Data addresses (byte address on the bus is four times these)
   localparam logic [7:0] A_IND      = 8'h00;
   localparam logic [7:0] A_PTR      = 8'h02;
   localparam logic [7:0] A_STAT     = 8'h04;
   localparam logic [7:0] A_WORK     = 8'h05;
   localparam logic [7:0] A_IFLG     = 8'h06;
   localparam logic [7:0] A_IEN      = 8'h07;
   localparam logic [7:0] A_PERI_LO  = 8'h08;
   localparam logic [7:0] A_SRAM_LO  = 8'h80;
   // Field positions
   localparam int         ST_PD      = 4;
   localparam int         ST_TO      = 3;
   localparam int         IF_TM      = 4;
   localparam int         IF_AD      = 1;
   localparam int         IF_PIN     = 0;
   localparam int         IE_GIE     = 7;
   // Implemented bits
   localparam logic [7:0] IFLG_MASK  = 8'h13;
   localparam logic [7:0] IEN_MASK   = 8'h93;
   localparam logic [7:0] IEN_INDIV  = 8'h13;
   // Program vectors
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_IRQ   = 16'h0004;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   // Values after external reset
   localparam logic       PD_RST     = 1'h1;
   localparam logic       TO_RST     = 1'h0;
   localparam logic [7:0] IFLG_RST   = 8'h00;
   localparam logic [7:0] IEN_RST    = 8'h00;

   typedef enum logic [2:0] {RD_IDLE = 3'h1, RD_WAIT = 3'h2, RD_RESP = 3'h4} csri_rd_t;
   typedef enum logic [1:0] {ALU_ADD = 2'h0, ALU_SUB = 2'h1, ALU_AND = 2'h2, ALU_OR = 2'h3} csri_aluop_t;

   typedef struct packed {
      logic        req;
      csri_aluop_t op;
      logic        toWork;
      logic [7:0]  opnd;
   } csri_alu_t;

   typedef struct packed {
      logic tm;
      logic ad;
      logic pin;
   } csri_evt_t;

   typedef struct packed {
      logic       sel;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csri_per_t;

   typedef struct packed {
      logic [7:0]  ptr;
      logic [7:0]  work;
      logic [7:0]  iflg;
      logic [7:0]  ien;
      logic        pd;
      logic        to;
      logic        dc;
      logic        cy;
      logic        z;
      logic        entry;
      logic [15:0] vec;
      logic [7:0]  aluRes;
      logic        awGot;
      logic        wGot;
      logic [7:0]  waddr;
      logic [7:0]  wdata;
      logic        wEn;
      logic        bvalid;
      csri_rd_t    rd;
      logic        rMem;
      logic [7:0]  rdata;
      csri_per_t   per;
   } csri_state_t;

   localparam csri_state_t ST_RST = '{pd: PD_RST, to: TO_RST, iflg: IFLG_RST, ien: IEN_RST,
                                      vec: VEC_RESET, rd: RD_IDLE, default: '0};
endpackage

// ===== rtl/csri_sram.sv
// General purpose data memory, one write and one registered read port.
// Assumes the caller holds address and enables stable for one clock.
module csri_sram (
   input  wire logic                         clk_sys,  // System clock
   input  wire logic                         we,       // Write strobe
   input  wire logic [csri_pkg::SRAM_AW-1:0] waddr,    // Write address
   input  wire logic [7:0]                   wdata,    // Write data
   input  wire logic                         re,       // Read strobe
   input  wire logic [csri_pkg::SRAM_AW-1:0] raddr,    // Read address
   output logic      [7:0]                   rdata     // Read data, one clock after re
);
   logic [7:0] mem [csri_pkg::SRAM_DEPTH];

   // No reset: contents stay unknown after any reset
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ===== rtl/csri_regbank.sv
// System special register bank with data map decode, indirect access, ALU flags, interrupts.
// Assumes CPU-side strobes and peripheral events are synchronous to clk_sys.

// Functional notes
// - Addresses 00h-07h are system registers, 08h-7Fh go to peripheral registers.
// - 128-byte SRAM at 80h-FFh, contents unknown after any reset.
// - Address 00h has no storage; accesses go to the pointer's target address.
// - An 8-bit pointer register at 02h supplies the indirect target.
// - Unimplemented system register bits read zero and ignore writes.
// - Status at 04h holds ALU flags, power-down and time-out; bits 7-5 unused.
// - Watchdog reset sets time-out to 1; power-down and ALU flags keep value.
// - Power-down flag set by power-on reset, cleared by sleep, not by halt.
// - Digit carry follows carry out of bit 3 on add and subtract.
// - Zero flag marks zero result; carry is inverted borrow on subtract.
// - Working register at 05h, readable and writable, ALU operand and result.
// - Enabled timer, converter or pin events set their interrupt flag.
// - Global enable and any flag: clear global enable, call address 0004h.
// - Interrupt entry happens only at an instruction boundary.
// - Flag register at 06h: timer bit 4, converter bit 1, pin bit 0.
// - Enable register at 07h: global 7, timer 4, converter 1, pin 0.
// - First fetch after reset from 0000h; 0004h is the only interrupt entry.
module csri_regbank (
   input  wire logic                        clk_sys,    // 20 MHz system clock
   input  wire logic                        rstn,       // Async external/low-voltage reset
   input  wire logic [csri_pkg::AXI_AW-1:0] awaddr,     // AXI write address
   input  wire logic                        awvalid,    // AXI write address valid
   output logic                             awready,    // AXI write address ready
   input  wire logic [31:0]                 wdata,      // AXI write data
   input  wire logic [3:0]                  wstrb,      // AXI write strobes
   input  wire logic                        wvalid,     // AXI write data valid
   output logic                             wready,     // AXI write data ready
   output logic      [1:0]                  bresp,      // AXI write response
   output logic                             bvalid,     // AXI write response valid
   input  wire logic                        bready,     // AXI write response ready
   input  wire logic [csri_pkg::AXI_AW-1:0] araddr,     // AXI read address
   input  wire logic                        arvalid,    // AXI read address valid
   output logic                             arready,    // AXI read address ready
   output logic      [31:0]                 rdata,      // AXI read data
   output logic      [1:0]                  rresp,      // AXI read response
   output logic                             rvalid,     // AXI read valid
   input  wire logic                        rready,     // AXI read ready
   input  csri_pkg::csri_alu_t              alu,        // ALU operation request
   output logic      [7:0]                  aluResult,  // Last ALU result
   input  wire logic                        instrEnd,   // Instruction boundary pulse
   input  wire logic                        sleepExec,  // Sleep instruction pulse
   input  wire logic                        wdtRst,     // Watchdog reset pulse
   input  csri_pkg::csri_evt_t              evt,        // Peripheral event pulses
   output logic                             irqEntry,   // Interrupt entry pulse
   output logic      [15:0]                 vecAddr,    // Program vector to fetch
   output csri_pkg::csri_per_t              per,        // Peripheral register access
   input  wire logic [7:0]                  perRdata    // Peripheral read data
);
   csri_pkg::csri_state_t st;
   csri_pkg::csri_state_t n;
   logic                  rstMeta;
   logic                  rstSync;
   logic                  memWe;
   logic                  memRe;
   logic [7:0]            memRd;
   logic [7:0]            eaW;
   logic [7:0]            eaR;
   logic                  doWrite;
   logic [9:0]            sum;
   logic                  dcExp;
   logic                  swIflgWr;

   // Indirect location resolves to the pointer's target
   function automatic logic [7:0] effAddr(input logic [7:0] a, input logic [7:0] p);
      return (a == csri_pkg::A_IND) ? p : a;
   endfunction

   // Add with nibble carry: {carry, digit carry, sum}
   function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
      hi = {1'h0, a[7:4]} + {1'h0, b[7:4]} + {4'h0, lo[4]};
      return {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rstMeta <= 1'h0;
         rstSync <= 1'h0;
      end else begin
         rstMeta <= 1'h1;
         rstSync <= rstMeta;
      end
   end

   // Handshake outputs; a pending write blocks new read starts to keep ports apart
   assign doWrite  = st.awGot && st.wGot;
   assign awready  = !st.awGot && !st.bvalid;
   assign wready   = !st.wGot && !st.bvalid;
   assign arready  = (st.rd == csri_pkg::RD_IDLE) && !doWrite;
   assign bvalid   = st.bvalid;
   assign bresp    = csri_pkg::RESP_OKAY;
   assign rvalid   = (st.rd == csri_pkg::RD_RESP);
   assign rresp    = csri_pkg::RESP_OKAY;
   assign rdata    = {24'h0, st.rdata};
   assign aluResult = st.aluRes;
   assign irqEntry = st.entry;
   assign vecAddr  = st.vec;
   assign per      = st.per;
   assign eaW      = effAddr(st.waddr, st.ptr);
   assign eaR      = effAddr(araddr[9:2], st.ptr);
   assign memRe    = arvalid && arready && eaR[7];
   assign memWe    = doWrite && st.wEn && eaW[7];
   assign sum      = (alu.op == csri_pkg::ALU_SUB) ? addc(alu.opnd, ~st.work, 1'h1)
                                                   : addc(alu.opnd, st.work, 1'h0);

   csri_sram u_sram (
      .clk_sys (clk_sys),
      .we      (memWe),
      .waddr   (eaW[6:0]),
      .wdata   (st.wdata),
      .re      (memRe),
      .raddr   (eaR[6:0]),
      .rdata   (memRd)
   );

   // Next state: bus first, then hardware events so that a set beats a clear
   always_comb begin
      n = st;
      n.entry   = 1'h0;
      n.per.sel = 1'h0;
      if (awvalid && awready) begin
         n.awGot = 1'h1;
         n.waddr = awaddr[9:2];
      end
      if (wvalid && wready) begin
         n.wGot  = 1'h1;
         n.wdata = wdata[7:0];
         n.wEn   = wstrb[0];
      end
      if (st.bvalid && bready) begin
         n.bvalid = 1'h0;
      end
      // Write decode, one register per data address
      if (doWrite) begin
         n.awGot  = 1'h0;
         n.wGot   = 1'h0;
         n.bvalid = 1'h1;
         if (st.wEn) begin
            if (eaW == csri_pkg::A_PTR) begin
               n.ptr = st.wdata;
            end else if (eaW == csri_pkg::A_STAT) begin
               {n.dc, n.cy, n.z} = st.wdata[2:0];
            end else if (eaW == csri_pkg::A_WORK) begin
               n.work = st.wdata;
            end else if (eaW == csri_pkg::A_IFLG) begin
               n.iflg = st.wdata & csri_pkg::IFLG_MASK;
            end else if (eaW == csri_pkg::A_IEN) begin
               n.ien = st.wdata & csri_pkg::IEN_MASK;
            end else if (eaW >= csri_pkg::A_PERI_LO && !eaW[7]) begin
               n.per = '{sel: 1'h1, we: 1'h1, addr: eaW, wdata: st.wdata};
            end
         end
      end
      // Read path; SRAM and peripherals need one wait cycle for registered data
      unique case (st.rd)
         csri_pkg::RD_IDLE: begin
            if (arvalid && arready) begin
               n.rMem  = eaR[7];
               n.rd    = csri_pkg::RD_WAIT;
               n.rdata = 8'h00;
               if (!eaR[7] && eaR >= csri_pkg::A_PERI_LO) begin
                  n.per = '{sel: 1'h1, we: 1'h0, addr: eaR, wdata: 8'h00};
               end else if (!eaR[7]) begin
                  n.rd = csri_pkg::RD_RESP;
                  if (eaR == csri_pkg::A_PTR) begin
                     n.rdata = st.ptr;
                  end else if (eaR == csri_pkg::A_STAT) begin
                     n.rdata = {3'h0, st.pd, st.to, st.dc, st.cy, st.z};
                  end else if (eaR == csri_pkg::A_WORK) begin
                     n.rdata = st.work;
                  end else if (eaR == csri_pkg::A_IFLG) begin
                     n.rdata = st.iflg;
                  end else if (eaR == csri_pkg::A_IEN) begin
                     n.rdata = st.ien;
                  end
               end
            end
         end
         csri_pkg::RD_WAIT: begin
            n.rdata = st.rMem ? memRd : perRdata;
            n.rd    = csri_pkg::RD_RESP;
         end
         csri_pkg::RD_RESP: begin
            if (rready) begin
               n.rd = csri_pkg::RD_IDLE;
            end
         end
      endcase
      // ALU flags override a software status write in the same cycle
      if (alu.req) begin
         unique case (alu.op)
            csri_pkg::ALU_ADD, csri_pkg::ALU_SUB: begin
               n.aluRes = sum[7:0];
               n.cy     = sum[9];
               n.dc     = sum[8];
            end
            csri_pkg::ALU_AND: n.aluRes = alu.opnd & st.work;
            csri_pkg::ALU_OR:  n.aluRes = alu.opnd | st.work;
         endcase
         n.z = (n.aluRes == 8'h00);
         if (alu.toWork) begin
            n.work = n.aluRes;
         end
      end
      // Halt has no input here: only sleep touches power-down
      if (sleepExec) begin
         n.pd = 1'h0;
      end
      // Event sets are ORed in after the software write
      n.iflg[csri_pkg::IF_TM]  = n.iflg[csri_pkg::IF_TM] | (evt.tm && st.ien[csri_pkg::IF_TM]);
      n.iflg[csri_pkg::IF_AD]  = n.iflg[csri_pkg::IF_AD] | (evt.ad && st.ien[csri_pkg::IF_AD]);
      n.iflg[csri_pkg::IF_PIN] = n.iflg[csri_pkg::IF_PIN] | (evt.pin && st.ien[csri_pkg::IF_PIN]);
      // Entry sampled only at the boundary; flags seen here are last cycle's
      if (instrEnd && st.ien[csri_pkg::IE_GIE] && (st.iflg != 8'h00)) begin
         n.ien[csri_pkg::IE_GIE] = 1'h0;
         n.entry = 1'h1;
         n.vec   = csri_pkg::VEC_IRQ;
      end
      // Watchdog restart: time-out set, flags and individual enables cleared, global enable and ALU flags kept
      if (wdtRst) begin
         n.to    = 1'h1;
         n.iflg  = 8'h00;
         n.ien   = n.ien & ~csri_pkg::IEN_INDIV;
         n.entry = 1'h0;
         n.vec   = csri_pkg::VEC_RESET;
      end
   end

   // Reset picks power-on values; global enable is taken as zero
   always_ff @(posedge clk_sys or negedge rstSync) begin
      if (!rstSync) begin
         st <= csri_pkg::ST_RST;
      end else begin
         st <= n;
      end
   end

   // Assertion helpers
   assign dcExp    = (({1'h0, alu.opnd[3:0]} + {1'h0, st.work[3:0]}) > 5'h0f);
   assign swIflgWr = doWrite && st.wEn && (eaW == csri_pkg::A_IFLG);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstSync);

   sequence s_entryReq;
      instrEnd && st.ien[csri_pkg::IE_GIE] && (st.iflg != 8'h00) && !wdtRst;
   endsequence
   sequence s_entryDone;
      irqEntry && !st.ien[csri_pkg::IE_GIE] && (vecAddr == csri_pkg::VEC_IRQ);
   endsequence

   property p_entry;
      s_entryReq |=> s_entryDone;
   endproperty
   a_entry: assert property (p_entry) else $error("interrupt entry missing");

   property p_boundary;
      $rose(irqEntry) |-> $past(instrEnd);
   endproperty
   a_boundary: assert property (p_boundary) else $error("entry off boundary");

   property p_flagSet;
      evt.tm && st.ien[csri_pkg::IF_TM] && !wdtRst |=> st.iflg[csri_pkg::IF_TM];
   endproperty
   a_flagSet: assert property (p_flagSet) else $error("timer flag not set");

   property p_flagHold;
      st.iflg[csri_pkg::IF_AD] && !swIflgWr && !wdtRst |=> st.iflg[csri_pkg::IF_AD];
   endproperty
   a_flagHold: assert property (p_flagHold) else $error("flag dropped");

   property p_wdt;
      wdtRst && !sleepExec && !alu.req |=> st.to && $stable(st.pd) && $stable(st.z);
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog state wrong");

   property p_sleep;
      sleepExec |=> !st.pd ##1 !st.pd;
   endproperty
   a_sleep: assert property (p_sleep) else $error("power-down not cleared");

   property p_zero;
      alu.req |=> st.z == (aluResult == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_dc;
      alu.req && alu.op == csri_pkg::ALU_ADD |=> st.dc == $past(dcExp);
   endproperty
   a_dc: assert property (p_dc) else $error("digit carry wrong");

   property p_rdResp;
      arvalid && arready |-> ##[1:2] rvalid;
   endproperty
   a_rdResp: assert property (p_rdResp) else $error("read answer late");

   property p_rsvdZero;
      rvalid |-> rdata[31:8] == 24'h0 && (st.iflg & ~csri_pkg::IFLG_MASK) == 8'h00 &&
                 (st.ien & ~csri_pkg::IEN_MASK) == 8'h00;
   endproperty
   a_rsvdZero: assert property (p_rsvdZero) else $error("upper read bits set");
endmodule

// ===== tb/csri_cpu_model.sv
// Stand-in for the CPU core and the peripheral registers around the bank.
// Assumes the bench calls its tasks; every drive lands just after a rising edge.
module csri_cpu_model (
   input  wire logic           clk_sys,    // System clock
   output csri_pkg::csri_alu_t alu,        // ALU request
   output logic                instrEnd,   // Instruction boundary pulse
   output logic                sleepExec,  // Sleep pulse
   output logic                wdtRst,     // Watchdog pulse
   output csri_pkg::csri_evt_t evt,        // Event pulses
   input  csri_pkg::csri_per_t per,        // Peripheral access
   output logic [7:0]          perRdata    // Peripheral read data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  idleData;
   logic [15:0] perWr;
   initial begin
      alu = '0;
      {wdtRst, sleepExec, instrEnd, evt} = '0;
      idleData = 8'h00;
      perWr = 16'h0000;
   end
   // Answer within the select cycle: the bank takes read data at the edge that ends it
   assign perRdata = (per.sel && !per.we) ? per.addr ^ 8'h5a : idleData;
   // Toggling filler so stale data never matches; last peripheral write kept for the bench
   always @(posedge clk_sys) begin
      idleData <= ~idleData;
      if (per.sel && per.we) perWr <= {per.addr, per.wdata};
   end
   // One ALU request, one cycle wide
   task automatic alu_op(input logic [1:0] op, input logic tw, input logic [7:0] d);
      @(posedge clk_sys);
      alu <= '{req: 1'b1, op: csri_pkg::csri_aluop_t'(op), toWork: tw, opnd: d};
      @(posedge clk_sys);
      alu.req <= 1'b0;
   endtask
   // Pulses {wdt, sleep, boundary, tm, ad, pin}; a quiet cycle follows as the no-op
   task automatic ctl(input logic [5:0] m);
      @(posedge clk_sys);
      {wdtRst, sleepExec, instrEnd, evt} <= m;
      @(posedge clk_sys);
      {wdtRst, sleepExec, instrEnd, evt} <= '0;
   endtask
endmodule

// ===== tb/csri_regbank_tb_top.sv
// Self-checking bench for the system register bank against an integer model.
// Assumes the bank answers AXI4-Lite at byte address four times the data address.
module csri_regbank_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk_sys, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic                awready, wready, bvalid, arready, rvalid, instrEnd, sleepExec, wdtRst, irqEntry;
   logic [9:0]          awaddr, araddr;
   logic [31:0]         wdata, rdata;
   logic [3:0]          wstrb;
   logic [1:0]          bresp, rresp;
   logic [7:0]          aluResult, perRdata, a;
   logic [15:0]         vecAddr;
   csri_pkg::csri_alu_t alu;
   csri_pkg::csri_evt_t evt;
   csri_pkg::csri_per_t per;
   int bad_count = 0, check_count = 0, entries = 0, i, d, r;
   int mPtr = 0, mWork = 0, mIflg = 0, mIen = 0, mPd = 1, mTo = 0, mDc = 0, mC = 0, mZ = 0;
   int mem[256];

   csri_regbank dut (.clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .alu(alu), .aluResult(aluResult), .instrEnd(instrEnd),
      .sleepExec(sleepExec), .wdtRst(wdtRst), .evt(evt), .irqEntry(irqEntry), .vecAddr(vecAddr),
      .per(per), .perRdata(perRdata));
   csri_cpu_model cpu (.clk_sys(clk_sys), .alu(alu), .instrEnd(instrEnd), .sleepExec(sleepExec),
      .wdtRst(wdtRst), .evt(evt), .per(per), .perRdata(perRdata));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Entry pulses are counted so a double or missing call shows up
   always @(posedge clk_sys) begin
      if (irqEntry === 1'b1) entries <= entries + 1;
   end

   // Model read: indirect through the pointer, peripherals answer addr^5a
   function automatic int mrd(int ad);
      if (ad == 0) ad = mPtr;
      if (ad == 0) return 0;
      if (ad >= 128) return mem[ad];
      if (ad >= 8) return ad ^ 'h5a;
      case (ad)
         2: return mPtr;
         4: return mPd * 16 + mTo * 8 + mDc * 4 + mC * 2 + mZ;
         5: return mWork;
         6: return mIflg;
         7: return mIen;
         default: return 0;
      endcase
   endfunction
   function automatic void mwr(int ad, int v);
      if (ad == 0) ad = mPtr;
      if (ad >= 128) mem[ad] = v;
      else if (ad == 2) mPtr = v;
      else if (ad == 4) begin
         mDc = v[2];
         mC = v[1];
         mZ = v[0];
      end
      else if (ad == 5) mWork = v;
      else if (ad == 6) mIflg = v & 'h13;
      else if (ad == 7) mIen = v & 'h93;
   endfunction

   task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: output %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic stuck();
      bad_count++;
      $display("unexpected at %0t: bus answer missing", $time);
      wrap_up();
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] ad, input logic [7:0] v, input logic s);
      int n;
      @(posedge clk_sys);
      awaddr <= {ad, 2'b00};
      wdata <= {24'($urandom), v};
      wstrb <= {3'($urandom), s};
      {awvalid, wvalid, bready} <= 3'b111;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) stuck();
      chk_out(16'(bresp), 16'(csri_pkg::RESP_OKAY));
      if (s) mwr(ad, v);
   endtask
   task automatic axi_rd(input logic [7:0] ad);
      int n;
      @(posedge clk_sys);
      araddr <= {ad, 2'b00};
      {arvalid, rready} <= 2'b11;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 50) stuck();
      chk_rd({rresp, rdata}, {csri_pkg::RESP_OKAY, 32'(mrd(ad))});
   endtask

   initial begin
      rstn = 1'b0;
      {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
      void'($urandom(56689));
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // Reset values and reserved addresses
      for (i = 1; i < 8; i++) if (i inside {1, 3, 4, 6, 7}) axi_rd(i[7:0]);
      chk_out(vecAddr, csri_pkg::VEC_RESET);
      axi_wr(8'h07, 8'hff, 1'b1);
      axi_rd(8'h07);
      axi_wr(8'h07, 8'h00, 1'b1);
      axi_wr(8'h04, 8'hff, 1'b1);
      axi_rd(8'h04);
      d = $urandom % 256;
      axi_wr(8'h05, d[7:0], 1'b1);
      axi_wr(8'h05, ~d[7:0], 1'b0);
      axi_rd(8'h05);
      // Memory, pointer and indirect port; peripheral window
      for (i = 0; i < 6; i++) begin
         a = 8'h80 + 8'($urandom % 128);
         d = $urandom % 256;
         axi_wr(a, d[7:0], 1'b1);
         axi_wr(8'h02, a, 1'b1);
         axi_rd(8'h00);
         axi_wr(8'h00, ~d[7:0], 1'b1);
         axi_rd(a);
         axi_rd(8'h08 + 8'(i * 23));
         axi_wr(8'h08 + 8'(i * 23), d[7:0], 1'b1);
         @(posedge clk_sys);
         chk_out(cpu.perWr, {8'h08 + 8'(i * 23), d[7:0]});
      end
      axi_wr(8'h02, 8'h00, 1'b1);
      axi_wr(8'h00, 8'h55, 1'b1);
      axi_rd(8'h00);
      // ALU flags: every operation, a zero result at i==5
      for (i = 0; i < 12; i++) begin
         d = (i == 5) ? mWork : $urandom % 256;
         cpu.alu_op(2'(i % 4), i[0], d[7:0]);
         case (i % 4)
            0: begin r = d + mWork; mC = r > 255; mDc = (d % 16 + mWork % 16) > 15; end
            1: begin r = d - mWork; mC = d >= mWork; mDc = d % 16 >= mWork % 16; end
            2: r = d & mWork;
            default: r = d | mWork;
         endcase
         r = r & 'hff;
         mZ = r == 0;
         if (i[0]) mWork = r;
         @(posedge clk_sys);
         chk_out(aluResult, 16'(r));
         axi_rd(8'h04);
         axi_rd(8'h05);
      end
      // Interrupts: disabled sources ignored, entry only at a boundary, once
      axi_wr(8'h07, 8'h90, 1'b1);
      cpu.ctl(6'b000011);
      axi_rd(8'h06);
      cpu.ctl(6'b000100);
      mIflg = 'h10;
      repeat (3) @(posedge clk_sys);
      chk_out(16'(entries), 16'h0);
      cpu.ctl(6'b001000);
      cpu.ctl(6'b001000);
      mIen = mIen & 'h7f;
      repeat (2) @(posedge clk_sys);
      chk_out(16'(entries), 16'h1);
      chk_out(vecAddr, csri_pkg::VEC_IRQ);
      axi_rd(8'h07);
      axi_rd(8'h06);
      axi_wr(8'h06, 8'h00, 1'b1);
      axi_wr(8'h07, 8'h13, 1'b1);
      cpu.ctl(6'b000011);
      mIflg = 'h03;
      axi_rd(8'h06);
      // Sleep after clearing flags, then watchdog
      axi_wr(8'h06, 8'h00, 1'b1);
      axi_wr(8'h07, 8'h80, 1'b1);
      cpu.ctl(6'b010000);
      mPd = 0;
      axi_rd(8'h04);
      cpu.ctl(6'b100000);
      mTo = 1;
      mIen = mIen & 'h80;
      axi_rd(8'h04);
      axi_rd(8'h07);
      axi_rd(8'h05);
      chk_out(vecAddr, csri_pkg::VEC_RESET);
      wrap_up();
   end
endmodule
